/* core/instruction_clock_watchdog.sv */
// Purpose: watchdog with 16-bit down counter, two underflow flags, reset pull-down
// Assumes: inst_tick is a one-cycle enable per instruction clock cycle
// Notes: decoder strobes are one-cycle pulses synchronous to sys_clk

// Operation
// RQ1: load all ones, decrement per instruction clock
// RQ2: underflow from zero sets first flag
// RQ3: underflow with first flag sets second, reset
// RQ4: watchdog reset drives reset pin low
// RQ5: program restarts within 65534 cycles
// RQ6: enable flag set on reset release
// RQ7: disable then restart clears enable flag
// RQ8: only system reset sets enable again
// RQ9: restart with first flag clears, skips next
// RQ10: restart with first flag clear: no skip
// RQ11: skip works while watchdog disabled
// RQ12: power-down entry reinitialises flag and counter
// RQ13: program restarts just before power-down
// RQ14: watchdog active after power-down return
// RQ15: system reset clears flags, reloads counter
module instruction_clock_watchdog
#(
    parameter int CNT_W = wd_pkg::CNT_W // counter width in bits
)
(
    input wire logic sys_clk, // 50 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic inst_tick, // instruction clock enable pulse
    input wire wd_pkg::cmd_s cmd, // decoder strobes
    output logic skip_next, // skip following instruction, pulse
    output logic reset_pull_oe_n, // reset pin pull-down enable, low = pulling
    output logic reset_pull_o, // reset pin drive level, always low
    output logic wd_enable_flag, // watchdog enable state
    output logic wd_first_underflow_flag, // first underflow flag
    output logic wd_second_underflow_flag, // second underflow flag
    output logic [15:0] wd_down_counter // live counter value
);
    wd_pkg::wd_state_s st_r;
    wd_pkg::wd_state_s st_nxt;
    logic underflow;

    // package width is the real one; a narrower count only shortens bench runs
    localparam logic [15:0] LOAD_VAL = wd_pkg::CNT_LOAD >> (wd_pkg::CNT_W - CNT_W);

    if (CNT_W < 2 || CNT_W > wd_pkg::CNT_W)
    begin : g_width_check
        $error("CNT_W must lie between 2 and the package counter width");
    end

    always_comb
    begin
        underflow = inst_tick && (st_r.cnt == wd_pkg::CNT_ZERO); // see RQ2
        st_nxt = st_r;
        st_nxt.skip = 1'b0;
        if (underflow)
        begin
            // reload rather than wrap, so a narrowed counter keeps its upper bits clear
            st_nxt.cnt = LOAD_VAL; // see RQ2
        end
        else if (inst_tick)
        begin
            st_nxt.cnt = st_r.cnt - 16'h0001; // see RQ1
        end
        if (underflow)
        begin
            if (st_r.first)
            begin
                st_nxt.second = 1'b1; // see RQ3
                // held until system reset; only enabled watchdog pulls the pin
                st_nxt.rst_pull = st_r.rst_pull | st_r.enable; // see RQ3
            end
            st_nxt.first = 1'b1; // see RQ2
        end
        if (cmd.restart)
        begin
            // a simultaneous underflow is not lost when the flag was already clear
            if (st_r.first)
            begin
                st_nxt.first = 1'b0; // see RQ9
                st_nxt.skip = 1'b1; // see RQ9
            end
            // skip decision ignores enable, so it keeps working when disabled; see RQ10 RQ11
            if (st_r.dis_armed)
            begin
                st_nxt.enable = 1'b0; // see RQ7
            end
        end
        // nothing here sets enable; only reset does; see RQ8
        if (cmd.instr || cmd.restart || cmd.disable_i)
        begin
            st_nxt.dis_armed = cmd.disable_i && !cmd.restart; // see RQ7
        end
        if (cmd.pd_enter)
        begin
            st_nxt.first = wd_pkg::FLAG_RST; // see RQ12
            st_nxt.cnt = LOAD_VAL; // see RQ12
            st_nxt.dis_armed = 1'b0;
        end
        // enable is untouched by power-down, so the watchdog runs after return; see RQ14
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r.cnt <= LOAD_VAL; // see RQ15
            st_r.enable <= wd_pkg::ENABLE_RST; // see RQ6
            st_r.first <= wd_pkg::FLAG_RST; // see RQ15
            st_r.second <= wd_pkg::FLAG_RST;
            st_r.dis_armed <= 1'b0;
            st_r.skip <= 1'b0;
            st_r.rst_pull <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign skip_next = st_r.skip;
    assign reset_pull_oe_n = ~st_r.rst_pull; // see RQ4
    assign reset_pull_o = 1'b0;
    assign wd_enable_flag = st_r.enable;
    assign wd_first_underflow_flag = st_r.first;
    assign wd_second_underflow_flag = st_r.second;
    assign wd_down_counter = st_r.cnt;

    sequence s_count_pulse;
        inst_tick && !cmd.pd_enter && st_r.cnt != wd_pkg::CNT_ZERO;
    endsequence

    sequence s_first_uf;
        inst_tick && st_r.cnt == wd_pkg::CNT_ZERO && !st_r.first && !cmd.pd_enter;
    endsequence

    sequence s_second_uf;
        inst_tick && st_r.cnt == wd_pkg::CNT_ZERO && st_r.first && st_r.enable;
    endsequence

    sequence s_disable_alone;
        cmd.disable_i && !cmd.restart && !cmd.instr && !cmd.pd_enter;
    endsequence

    sequence s_decoder_idle;
        !cmd.disable_i && !cmd.restart && !cmd.instr && !cmd.pd_enter;
    endsequence

    sequence s_restart_alone;
        cmd.restart && !cmd.disable_i && !cmd.instr && !cmd.pd_enter;
    endsequence

    sequence s_disable_then_restart;
        s_disable_alone ##1 s_decoder_idle ##1 s_restart_alone;
    endsequence

    chk_count_step: assert property ( // see RQ1
        @(posedge sys_clk) disable iff (!rstn)
        s_count_pulse
        |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
        else $error("counter did not decrement");

    chk_count_hold: assert property ( // see RQ1
        @(posedge sys_clk) disable iff (!rstn)
        !inst_tick && !cmd.pd_enter
        |=> $stable(st_r.cnt))
        else $error("counter moved without a tick");

    chk_first_set: assert property ( // see RQ2
        @(posedge sys_clk) disable iff (!rstn)
        inst_tick && st_r.cnt == wd_pkg::CNT_ZERO && !cmd.pd_enter && !(cmd.restart && st_r.first)
        |=> st_r.first)
        else $error("first flag not set on underflow");

    chk_uf_reload: assert property ( // see RQ2
        @(posedge sys_clk) disable iff (!rstn)
        inst_tick && st_r.cnt == wd_pkg::CNT_ZERO && !cmd.pd_enter
        |=> st_r.cnt == LOAD_VAL)
        else $error("counter not reloaded on underflow");

    chk_first_only: assert property ( // see RQ2
        @(posedge sys_clk) disable iff (!rstn)
        s_first_uf
        |=> st_r.second == $past(st_r.second))
        else $error("first underflow touched second flag");

    chk_second_reset: assert property ( // see RQ3
        @(posedge sys_clk) disable iff (!rstn)
        s_second_uf
        |=> st_r.second && !reset_pull_oe_n)
        else $error("second underflow did not raise reset");

    chk_second_sticky: assert property ( // see RQ3
        @(posedge sys_clk) disable iff (!rstn)
        st_r.second
        |=> st_r.second)
        else $error("second flag cleared without reset");

    chk_pull_cause: assert property ( // see RQ3
        @(posedge sys_clk) disable iff (!rstn)
        !reset_pull_oe_n
        |-> st_r.second)
        else $error("reset pull without second flag");

    chk_pull_hold: assert property ( // see RQ4
        @(posedge sys_clk) disable iff (!rstn)
        !reset_pull_oe_n
        |=> !reset_pull_oe_n && reset_pull_o == 1'b0)
        else $error("reset pull released early");

    chk_pull_start: assert property ( // see RQ4
        @(posedge sys_clk) disable iff (!rstn)
        $fell(reset_pull_oe_n)
        |-> $past(st_r.enable))
        else $error("reset pull started while disabled");

    chk_pull_needs_enable: assert property ( // see RQ4
        @(posedge sys_clk) disable iff (!rstn)
        inst_tick && st_r.cnt == wd_pkg::CNT_ZERO && st_r.first && !st_r.enable && !st_r.rst_pull
        |=> reset_pull_oe_n)
        else $error("disabled watchdog pulled reset");

    chk_reset_enable: assert property ( // see RQ6
        @(posedge sys_clk)
        $rose(rstn)
        |-> st_r.enable)
        else $error("enable not set after reset");

    chk_disable_pair: assert property ( // see RQ7
        @(posedge sys_clk) disable iff (!rstn)
        cmd.restart && !st_r.dis_armed && st_r.enable
        |=> st_r.enable)
        else $error("restart alone disabled watchdog");

    chk_pair_clears: assert property ( // see RQ7
        @(posedge sys_clk) disable iff (!rstn)
        s_disable_then_restart
        |=> !st_r.enable)
        else $error("disable then restart kept watchdog on");

    chk_arm_set: assert property ( // see RQ7
        @(posedge sys_clk) disable iff (!rstn)
        cmd.disable_i && !cmd.restart && !cmd.pd_enter
        |=> st_r.dis_armed)
        else $error("disable instruction not remembered");

    chk_arm_break: assert property ( // see RQ7
        @(posedge sys_clk) disable iff (!rstn)
        cmd.instr && !cmd.disable_i
        |=> !st_r.dis_armed)
        else $error("other instruction kept pair armed");

    chk_enable_sticky: assert property ( // see RQ8
        @(posedge sys_clk) disable iff (!rstn)
        !st_r.enable
        |=> !st_r.enable)
        else $error("enable set without reset");

    chk_skip_taken: assert property ( // see RQ9
        @(posedge sys_clk) disable iff (!rstn)
        cmd.restart && st_r.first
        |=> skip_next && !st_r.first)
        else $error("restart with flag did not skip");

    chk_skip_single: assert property ( // see RQ9
        @(posedge sys_clk) disable iff (!rstn)
        skip_next
        |=> !skip_next)
        else $error("skip held longer than one cycle");

    chk_no_skip: assert property ( // see RQ10
        @(posedge sys_clk) disable iff (!rstn)
        cmd.restart && !st_r.first
        |=> !skip_next)
        else $error("restart without flag skipped");

    chk_skip_disabled: assert property ( // see RQ11
        @(posedge sys_clk) disable iff (!rstn)
        cmd.restart && st_r.first && !st_r.enable
        |=> skip_next)
        else $error("skip lost while disabled");

    chk_pd_init: assert property ( // see RQ12
        @(posedge sys_clk) disable iff (!rstn)
        cmd.pd_enter
        |=> st_r.cnt == LOAD_VAL && !st_r.first)
        else $error("power-down did not reinitialise");

    chk_pd_enable: assert property ( // see RQ14
        @(posedge sys_clk) disable iff (!rstn)
        cmd.pd_enter && !cmd.restart
        |=> st_r.enable == $past(st_r.enable))
        else $error("power-down changed enable");

    chk_pd_disarm: assert property ( // see RQ14
        @(posedge sys_clk) disable iff (!rstn)
        cmd.pd_enter
        |=> !st_r.dis_armed)
        else $error("pair survived power-down");

    chk_reset_clear: assert property ( // see RQ15
        @(posedge sys_clk)
        $rose(rstn)
        |-> !st_r.first && !st_r.second && reset_pull_oe_n && !skip_next && st_r.cnt == LOAD_VAL)
        else $error("reset did not clear watchdog state");
endmodule

/* core/wd_pkg.sv */
// Purpose: shared constants and carrier types for the instruction clock watchdog
// Assumes: one system clock, instruction clock arrives as a one-cycle enable
// Notes: counter width and load value live here only
package wd_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_LOAD = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic ENABLE_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;

    typedef struct packed {
        logic restart;   // restart instruction executed
        logic disable_i; // disable instruction executed
        logic instr;     // any instruction retired
        logic pd_enter;  // power-down entry
    } cmd_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic enable;
        logic first;
        logic second;
        logic dis_armed;
        logic skip;
        logic rst_pull;
    } wd_state_s;
endpackage

/* verification/decoder_model.sv */
// Purpose: decoder stand-in driving strobes and ticks
// Assumes: drives 1 ns after sys_clk rises
// Notes: held for n edges, then idle
module decoder_model
(
    input wire logic sys_clk, // system clock
    output wd_pkg::cmd_s cmd, // decoder strobes
    output logic inst_tick // instruction clock enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cmd = '0;
        inst_tick = 1'b0;
    end
    // restart spacing is left to the caller
    task automatic run(input wd_pkg::cmd_s c, input logic tk, input int n);
        @(posedge sys_clk);
        #1 cmd = c;
        inst_tick = tk;
        repeat (n) @(posedge sys_clk);
        #1 cmd = '0;
        inst_tick = 1'b0;
    endtask
endmodule

/* verification/instruction_clock_watchdog_tb_top.sv */
// Purpose: self-checking bench for the watchdog
// Assumes: one tick per cycle
// Notes: counter narrowed to 8 bits so two underflows take a few hundred cycles
module instruction_clock_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    wd_pkg::cmd_s cmd;
    logic inst_tick, skip_next, oe_n, pull_o, en, f1, f2;
    logic [15:0] cnt;
    int err_total = 0;
    int comparisons = 0;
    localparam int TB_CNT_W = 8;
    localparam logic [15:0] LOAD = wd_pkg::CNT_LOAD >> (wd_pkg::CNT_W - TB_CNT_W);
    localparam int FULL = 1 << TB_CNT_W; // ticks from load to underflow
    wire logic [15:0] st = {10'h000, en, f1, f2, oe_n, pull_o, skip_next};
    always #10 sys_clk = ~sys_clk;
    decoder_model dec (.sys_clk(sys_clk), .cmd(cmd), .inst_tick(inst_tick));
    instruction_clock_watchdog #(.CNT_W(TB_CNT_W)) uut (.sys_clk(sys_clk), .rstn(rstn), .inst_tick(inst_tick),
        .cmd(cmd), .skip_next(skip_next), .reset_pull_oe_n(oe_n), .reset_pull_o(pull_o), .wd_enable_flag(en),
        .wd_first_underflow_flag(f1), .wd_second_underflow_flag(f2), .wd_down_counter(cnt));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 rstn = 1'b1;
    endtask
    task automatic t_count();
        chk("cnt", LOAD, cnt);
        chk("status", 16'h0024, st);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0024, st);
        dec.run(4'h2, 1'b1, 3);
        chk("cnt", LOAD - 16'h0003, cnt);
        dec.run(4'h1, 1'b0, 1);
        chk("cnt", LOAD, cnt);
        $display("test count done");
    endtask
    task automatic t_disable();
        dec.run(4'h4, 1'b0, 1);
        dec.run(4'h2, 1'b0, 1);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0024, st);
        dec.run(4'h4, 1'b0, 1);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0004, st);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0004, st);
        dec.run(4'h2, 1'b1, FULL);
        chk("status", 16'h0014, st);
        dec.run(4'h2, 1'b1, FULL);
        chk("status", 16'h001c, st);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h000d, st);
        do_reset();
        chk("status", 16'h0024, st);
        $display("test disable done");
    endtask
    task automatic t_underflow();
        dec.run(4'h2, 1'b1, FULL - 1);
        chk("cnt", 16'h0000, cnt);
        dec.run(4'h2, 1'b1, 1);
        chk("cnt", LOAD, cnt);
        chk("status", 16'h0034, st);
        dec.run(4'h2, 1'b1, FULL);
        chk("status", 16'h0038, st);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0029, st);
        do_reset();
        chk("status", 16'h0024, st);
        $display("test underflow done");
    endtask
    task automatic t_power_down();
        dec.run(4'h2, 1'b1, FULL);
        chk("status", 16'h0034, st);
        dec.run(4'h1, 1'b0, 1);
        chk("cnt", LOAD, cnt);
        chk("status", 16'h0024, st);
        dec.run(4'h2, 1'b1, FULL);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0025, st);
        dec.run(4'h1, 1'b0, 1);
        dec.run(4'h4, 1'b0, 1);
        dec.run(4'h1, 1'b0, 1);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0024, st);
        dec.run(4'h4, 1'b0, 1);
        dec.run(4'h8, 1'b0, 1);
        chk("status", 16'h0004, st);
        $display("test power-down done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        do_reset();
        t_count();
        t_disable();
        t_underflow();
        t_power_down();
        tally_and_finish();
    end
    // tests take about 32 us; allow several times that
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end
endmodule
